// File: inc/fbp_defines.svh
// Constants for the flash block protection checker.
// Assumes a byte-addressed flash of 16 KB behind a simple erase/program sequencer.
//
// Summary of operation
// [R1] Flash holds 16 KB as 1 KB erase units, each erasable alone.
// [R2] After an erase completes every bit of that unit reads as one.
// [R3] Protection is per 2 KB unit, two erase units each, independent settings.
// [R4] Read-only units refuse all erase and program requests.
// [R5] Execute-only units refuse erase and program, serve only instruction fetch reads.
// [R6] Protection is checked before an operation starts; refused requests change nothing.
`ifndef FBP_DEFINES_SVH
`define FBP_DEFINES_SVH

`define FBP_FLASH_BYTES   16384
`define FBP_ERASE_BYTES   1024
`define FBP_PROT_BYTES    2048
`define FBP_ADDR_W        14
`define FBP_ERASED_WORD   32'hffff_ffff
`define FBP_ERASE_NS      1000
`define FBP_ERASE_CYC     ((`FBP_ERASE_NS + 9) / 10)
`define FBP_PROG_NS       100
`define FBP_PROG_CYC      ((`FBP_PROG_NS + 9) / 10)

`endif

// File: inc/fbp_pkg.sv
// Types for the flash block protection checker.
// Assumes nothing beyond the defines header.
package fbp_pkg;
	typedef enum logic [1:0] {FBP_IDLE, FBP_ERASE, FBP_PROG} fbp_state_e;
endpackage

// File: rtl/fbp_flash_guard.sv
// Flash array with protection checker and erase/program sequencer.
// Assumes requests come from logic on clk_sys; one operation in flight at a time.
//
// Behaviour in brief:
// - Protection settings arrive as levels, one read-only and one execute-only bit
//   per 2 KB unit, both on clk_sys, so they pass no synchroniser.
// - An erase or program request is taken only while the sequencer is idle.
//   Requests that arrive while it is busy are ignored, not queued.
// - A locked unit answers with a one-cycle refusal pulse and the array is never touched.
// - Reads answer one cycle after the request. Fetch data holds until the next fetch,
//   and data-side data is zero whenever nothing is being served.
// - Debug reads go down the data path and get the same refusal as data reads.
// Limitation: the array is not reset, so words that were never erased read unknown.
`timescale 1ns/1ps
`default_nettype none
`include "fbp_defines.svh"

module fbp_flash_guard #(
	parameter int unsigned NUM_PROT     = `FBP_FLASH_BYTES / `FBP_PROT_BYTES,
	parameter int unsigned ERASE_CYCLES = `FBP_ERASE_CYC,
	parameter int unsigned PROG_CYCLES  = `FBP_PROG_CYC
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rstn,
	input  wire logic [NUM_PROT-1:0]    prot_ro,
	input  wire logic [NUM_PROT-1:0]    prot_xo,
	// Instruction fetch port
	input  wire logic                   ifetch_req,
	input  wire logic [`FBP_ADDR_W-1:0] ifetch_addr,
	output logic                        ifetch_ack,
	output logic [31:0]                 ifetch_rdata,
	// Data and debug read port
	input  wire logic                   dread_req,
	input  wire logic                   dread_dbg,
	input  wire logic [`FBP_ADDR_W-1:0] dread_addr,
	output logic                        dread_ack,
	output logic                        dread_err,
	output logic [31:0]                 dread_rdata,
	// Erase and program requests
	input  wire logic                   erase_req,
	input  wire logic                   prog_req,
	input  wire logic [`FBP_ADDR_W-1:0] op_addr,
	input  wire logic [31:0]            prog_wdata,
	output logic                        op_ready,
	output logic                        op_done,
	output logic                        op_refused
);

	localparam int unsigned WORDS      = `FBP_FLASH_BYTES / 4;
	localparam int unsigned UNIT_WORDS = `FBP_ERASE_BYTES / 4;
	localparam int unsigned PW         = $clog2(NUM_PROT);
	localparam int unsigned CW         = 16;

	////////////////////////////////////////////////////////////////////////////
	// Array: 16 KB of words in 1 KB erase units
	logic [31:0] mem_q [WORDS]; // [R1]

	// Protection unit index: two erase units share one setting
	logic [PW-1:0] op_pu;
	logic [PW-1:0] if_pu;
	logic [PW-1:0] dr_pu;
	assign op_pu = op_addr[`FBP_ADDR_W-1 -: PW]; // [R3]
	assign if_pu = ifetch_addr[`FBP_ADDR_W-1 -: PW];
	assign dr_pu = dread_addr[`FBP_ADDR_W-1 -: PW];

	////////////////////////////////////////////////////////////////////////////
	// Sequencer state
	fbp_pkg::fbp_state_e state_q, state_d;
	logic [CW-1:0]                cnt_q, cnt_d;
	logic [`FBP_ADDR_W-3:0]       wa_q, wa_d;
	logic [31:0]                  wd_q, wd_d;
	logic                         done_q, done_d;
	logic                         refused_q, refused_d;
	logic                         locked;

	// Either protection mode blocks modification
	assign locked   = prot_ro[op_pu] | prot_xo[op_pu]; // [R4] [R5]
	assign op_ready = (state_q == fbp_pkg::FBP_IDLE);

	// Timing of an accepted operation, counted from the edge that takes it:
	// the counter is loaded with the cycle count less one and runs down to zero,
	// and the array is written on the edge that leaves the busy state.
	// The done pulse comes from that same edge, so a reader that waits for it
	// always sees the new contents.
	// Check happens in IDLE before the sequencer leaves it, so a refusal never touches memory
	always_comb
	begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		wa_d      = wa_q;
		wd_d      = wd_q;
		done_d    = 1'b0;
		refused_d = 1'b0;
		case (state_q)
			fbp_pkg::FBP_IDLE:
			begin
				if (erase_req | prog_req)
				begin
					if (locked)
						refused_d = 1'b1; // [R6]
					else
					begin
						wa_d    = op_addr[`FBP_ADDR_W-1:2];
						wd_d    = prog_wdata;
						state_d = erase_req ? fbp_pkg::FBP_ERASE : fbp_pkg::FBP_PROG;
						cnt_d   = erase_req ? CW'(ERASE_CYCLES - 1) : CW'(PROG_CYCLES - 1);
					end
				end
			end
			fbp_pkg::FBP_ERASE, fbp_pkg::FBP_PROG:
			begin
				if (cnt_q == '0)
				begin
					done_d  = 1'b1;
					state_d = fbp_pkg::FBP_IDLE;
				end
				else
					cnt_d = cnt_q - 1'b1;
			end
			default: state_d = fbp_pkg::FBP_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			state_q   <= fbp_pkg::FBP_IDLE;
			cnt_q     <= '0;
			wa_q      <= '0;
			wd_q      <= '0;
			done_q    <= 1'b0;
			refused_q <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			wa_q      <= wa_d;
			wd_q      <= wd_d;
			done_q    <= done_d;
			refused_q <= refused_d;
		end
	end

	// Both answers are one-cycle pulses straight from flip-flops
	assign op_done    = done_q;
	assign op_refused = refused_q;

	////////////////////////////////////////////////////////////////////////////
	// Commit at end of operation; erase fills only the addressed 1 KB unit with ones
	// Memory is not reset: flash contents survive reset in a real part
	logic commit_erase;
	logic commit_prog;
	assign commit_erase = rstn && (cnt_q == '0) && (state_q == fbp_pkg::FBP_ERASE);
	assign commit_prog  = rstn && (cnt_q == '0) && (state_q == fbp_pkg::FBP_PROG);

	always_ff @(posedge clk_sys)
	begin
		if (commit_erase)
		begin
			for (int i = 0; i < UNIT_WORDS; i++)
				mem_q[{wa_q[`FBP_ADDR_W-3:8], 8'(i)}] <= `FBP_ERASED_WORD; // [R1] [R2]
		end
		else if (commit_prog)
			mem_q[wa_q] <= mem_q[wa_q] & wd_q; // Programming only clears bits
	end

	////////////////////////////////////////////////////////////////////////////
	// Read ports: fetch always served, data/debug refused on execute-only units
	logic        if_ack_q, if_ack_d;
	logic        dr_ack_q, dr_ack_d;
	logic        dr_err_q, dr_err_d;
	logic [31:0] if_data_q, if_data_d;
	logic [31:0] dr_data_q, dr_data_d;
	logic        dr_deny;
	assign dr_deny = prot_xo[dr_pu]; // [R5]

	// Next read answers; a denied read returns zero so no protected bit leaks
	always_comb
	begin
		if_ack_d  = ifetch_req;
		dr_ack_d  = dread_req;
		dr_err_d  = dread_req & dr_deny; // [R5]
		if_data_d = if_data_q;
		dr_data_d = '0;
		if (ifetch_req)
			if_data_d = mem_q[ifetch_addr[`FBP_ADDR_W-1:2]];
		if (dread_req & ~dr_deny)
			dr_data_d = mem_q[dread_addr[`FBP_ADDR_W-1:2]]; // [R5]
	end

	// Read answer registers
	always_ff @(posedge clk_sys)
	begin
		if (!rstn)
		begin
			if_ack_q  <= 1'b0;
			dr_ack_q  <= 1'b0;
			dr_err_q  <= 1'b0;
			if_data_q <= '0;
			dr_data_q <= '0;
		end
		else
		begin
			if_ack_q  <= if_ack_d;
			dr_ack_q  <= dr_ack_d;
			dr_err_q  <= dr_err_d;
			if_data_q <= if_data_d;
			dr_data_q <= dr_data_d;
		end
	end

	// Read answers leave straight from flip-flops
	assign ifetch_ack   = if_ack_q;
	assign ifetch_rdata = if_data_q;
	assign dread_ack    = dr_ack_q;
	assign dread_err    = dr_err_q;
	assign dread_rdata  = dr_data_q;

endmodule // fbp_flash_guard
`default_nettype wire

// File: verification/fbp_guard_asserts.sv
// Port checker for the flash guard.
// Bound to every fbp_flash_guard; default sizes.
`timescale 1ns/1ps
`default_nettype none
module fbp_guard_asserts (
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic [7:0]  prot_ro,
	input wire logic [7:0]  prot_xo,
	input wire logic        ifetch_req,
	input wire logic        ifetch_ack,
	input wire logic        dread_req,
	input wire logic [13:0] dread_addr,
	input wire logic        dread_ack,
	input wire logic        dread_err,
	input wire logic [31:0] dread_rdata,
	input wire logic        erase_req,
	input wire logic        prog_req,
	input wire logic [13:0] op_addr,
	input wire logic        op_ready,
	input wire logic        op_done,
	input wire logic        op_refused
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Taken op and whether its 2 KB unit is locked
	wire go = op_ready & (erase_req | prog_req);
	wire lk = prot_ro[op_addr[13:11]] | prot_xo[op_addr[13:11]];
	wire dx = prot_xo[dread_addr[13:11]];
	a_lock_refuse: assert property (go && lk |=> op_refused && !op_done)
		else $error("locked op not refused");
	a_open_start: assert property (go && !lk |=> !op_ready && !op_refused)
		else $error("open op not started");
	a_refuse_idle: assert property (op_refused |-> op_ready && !op_done)
		else $error("refused op left busy");
	a_xo_deny: assert property (dread_req && dx |=> dread_ack && dread_err && dread_rdata == 0)
		else $error("xo data read served");
	a_data_ok: assert property (dread_req && !dx |=> dread_ack && !dread_err)
		else $error("data read refused");
	a_fetch_ack: assert property (ifetch_req |=> ifetch_ack)
		else $error("fetch not served");
endmodule // fbp_guard_asserts
bind fbp_flash_guard fbp_guard_asserts u_chk (.*);
`default_nettype wire

// File: verification/fbp_cpu_model.sv
// Processor side: fetch, data and debug reads.
// Pins change at the falling edge; released address inverted.
`timescale 1ns/1ps
`default_nettype none
module fbp_cpu_model (
	input  wire logic  clk_sys,
	output logic       ifetch_req,
	output logic [13:0] ifetch_addr,
	output logic       dread_req,
	output logic       dread_dbg,
	output logic [13:0] dread_addr
);
	initial
	begin
		ifetch_req = 1'b0;
		dread_req = 1'b0;
		dread_dbg = 1'b0;
		ifetch_addr = 14'h0;
		dread_addr = 14'h0;
	end
	// One read: k 0 fetch, 1 data, 2 debug
	task automatic rd(input logic [1:0] k, input logic [13:0] a);
		@(negedge clk_sys);
		ifetch_req = (k == 2'h0);
		dread_req = (k != 2'h0);
		dread_dbg = k[1];
		ifetch_addr = a;
		dread_addr = a;
		@(negedge clk_sys);
		ifetch_req = 1'b0;
		dread_req = 1'b0;
		ifetch_addr = ~a;
		dread_addr = ~a;
	endtask
endmodule // fbp_cpu_model
`default_nettype wire

// File: verification/fbp_flash_guard_tb.sv
// Bench: op table, then reads and erase independence.
// Short erase and program counts keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_guard_tb;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] prot_ro = 8'h0;
	logic [7:0] prot_xo = 8'h0;
	logic erase_req = 1'b0;
	logic prog_req = 1'b0;
	logic [13:0] op_addr = 14'h0;
	logic [31:0] prog_wdata = 32'h0;
	wire ifetch_req, dread_req, dread_dbg, ifetch_ack, dread_ack, dread_err;
	wire op_ready, op_done, op_refused;
	wire [13:0] ifetch_addr, dread_addr;
	wire [31:0] ifetch_rdata, dread_rdata;
	int bad_count = 0;
	int checked = 0;
	// Rows {erase, addr, refused}; ro units 1,3 and xo units 4,5
	logic [15:0] rows [8] = '{16'h8000, 16'h8800, 16'h9001, 16'h1809,
		16'hc001, 16'h57f9, 16'hf800, 16'h0008};
	fbp_flash_guard #(.ERASE_CYCLES(2), .PROG_CYCLES(2)) dut (.*);
	fbp_cpu_model cpu (.*);
	always #5 clk_sys = ~clk_sys;
	////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s exp %h saw %h", n, e, s);
		end
	endtask
	// One op, then wait a bounded time for its answer
	task automatic op(input logic e, input logic [13:0] a, input logic r);
		int i;
		@(negedge clk_sys);
		erase_req = e;
		prog_req = !e;
		op_addr = a;
		prog_wdata = 32'h1234_5678;
		@(negedge clk_sys);
		erase_req = 1'b0;
		prog_req = 1'b0;
		op_addr = ~a;
		for (i = 0; i < 9 && !(op_done || op_refused); i++)
			@(negedge clk_sys);
		chk("refused", {31'h0, op_refused}, {31'h0, r});
		chk("done", {31'h0, op_done}, {31'h0, !r});
	endtask
	task automatic rf(input logic [1:0] k, input logic [13:0] a, input logic [31:0] e);
		cpu.rd(k, a);
		chk("rdata", k == 2'h0 ? ifetch_rdata : dread_rdata, e);
		if (k != 2'h0)
			chk("err", {31'h0, dread_err}, {31'h0, e == 32'h0});
	endtask
	initial
	begin
		repeat (8) @(negedge clk_sys);
		rstn = 1'b1;
		op(1'b1, 14'h0c00, 1'b0);
		op(1'b1, 14'h2000, 1'b0);
		prot_ro = 8'h0a;
		prot_xo = 8'h30;
		foreach (rows[i])
			op(rows[i][15], rows[i][14:1], rows[i][0]);
		$display("table done");
		rf(2'h0, 14'h0004, 32'h1234_5678);
		rf(2'h0, 14'h07fc, 32'hffff_ffff);
		rf(2'h0, 14'h0c04, 32'hffff_ffff);
		rf(2'h1, 14'h0c04, 32'hffff_ffff);
		rf(2'h0, 14'h2000, 32'hffff_ffff);
		rf(2'h1, 14'h2000, 32'h0);
		rf(2'h2, 14'h2ffc, 32'h0);
		op(1'b0, 14'h0404, 1'b0);
		op(1'b1, 14'h0000, 1'b0);
		rf(2'h0, 14'h0404, 32'h1234_5678);
		rf(2'h0, 14'h0004, 32'hffff_ffff);
		$display("read tests done");
		test_done();
	end
	// Watchdog well beyond the expected run of under a hundred cycles
	initial
	begin
		#20000;
		bad_count++;
		test_done();
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
endmodule // fbp_flash_guard_tb
`default_nettype wire
